/* logic/cms_config_mode_select.sv */
// Behaviour
// - The three mode inputs decode to master serial, slave serial, master parallel, slave parallel or scan (the other three codes to no mode), with width 1 or 8.
// - Master modes drive the configuration clock, slave modes take it in, scan mode uses the test clock.
// - Serial pass-through carries chain data only in the two serial modes.
// - A high pull-up control input disables user I/O pull-ups for the whole loading period.
// - A low pull-up control input enables user I/O pull-ups during loading.
// - With persist set, configuration pins keep their role after loading.
// - Without persist, configuration pins go to user I/O after loading, all together through the one config_pins_dedicated output.
// - Scan pins keep their test role regardless of persist.
// - A serial chain stream longer than 4,294,967,264 bits is not accepted.
// - Loading through the scan chain has no length limit.
// - Serial data is sampled on rising clock edges and pass-through changes on falling edges.
// - The master clock starts at 6 MHz and fast_clk_en switches it to a half-period of fast_half_cycles clock cycles.
// - Scan loading is accepted in every mode, but loses to a serial or parallel load in the same cycle; scan mode only turns the others off.
`timescale 1ns/1ns
module cms_config_mode_select
	import cms_pkg::*;
#(
	parameter int DIV_WIDTH = CMS_DIV_WIDTH
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic mode_select_bit0,
	input wire logic mode_select_bit1,
	input wire logic mode_select_bit2,
	input wire logic io_pullup_disable,
	input wire logic program_request_n,
	input wire logic persist,
	input wire logic load_done,
	input wire logic fast_clk_en,
	input wire logic [DIV_WIDTH-1:0] fast_half_cycles,
	input wire logic config_clock_in,
	input wire logic test_clock,
	input wire logic serial_data_in,
	input wire logic [7:0] parallel_data_in,
	input wire logic chain_data_in,
	input wire logic scan_load_active,
	input wire logic scan_data_in,
	input wire logic busy_in,
	output logic config_clock_out,
	output logic config_clock_oe,
	output logic pass_out,
	output logic pass_oe,
	output logic [7:0] data_word,
	output logic [3:0] data_width,
	output logic data_valid,
	output logic busy,
	output logic loading,
	output logic user_pullup_en,
	output logic config_pins_dedicated,
	output logic scan_pins_dedicated,
	output logic length_error,
	output logic [2:0] mode
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [15:0] raw_in;
	logic [15:0] syn_in;
	logic s_m0, s_m1, s_m2, s_pud, s_prog_n, s_config_clock, s_tck, s_din, s_chain, s_sdi, s_busy;
	logic [7:0] s_pdata;

	assign raw_in = {mode_select_bit0, mode_select_bit1, mode_select_bit2, io_pullup_disable,
		program_request_n, config_clock_in, test_clock, serial_data_in, chain_data_in,
		scan_data_in, busy_in, 5'h00};
	assign {s_m0, s_m1, s_m2, s_pud, s_prog_n, s_config_clock, s_tck, s_din, s_chain, s_sdi, s_busy}
		= syn_in[15:5];

	cms_sync #(.WIDTH(16)) u_sync (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.d(raw_in),
		.q(syn_in)
	);

	cms_sync #(.WIDTH(8)) u_sync_pd (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.d(parallel_data_in),
		.q(s_pdata)
	);

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	function automatic cms_mode_e cms_decode(input logic [2:0] code);
		cms_mode_e m;
		case (code)
			CMS_CODE_MSER: m = CMS_MODE_MSER;
			CMS_CODE_SSER: m = CMS_MODE_SSER;
			CMS_CODE_MPAR: m = CMS_MODE_MPAR;
			CMS_CODE_SPAR: m = CMS_MODE_SPAR;
			CMS_CODE_SCAN: m = CMS_MODE_SCAN;
			default: m = CMS_MODE_NONE;
		endcase
		return m;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	cms_mode_e cur_mode, next_cur_mode;
	logic prog_d, next_prog_d;
	logic config_clock_d, next_config_clock_d;
	logic tck_d, next_tck_d;
	logic gen_clk, next_gen_clk;
	logic [DIV_WIDTH-1:0] div_cnt, next_div_cnt;
	logic [31:0] bit_cnt, next_bit_cnt;
	logic next_config_clock_out, next_config_clock_oe, next_pass_out, next_pass_oe;
	logic [7:0] next_data_word;
	logic [3:0] next_data_width;
	logic next_data_valid, next_busy, next_loading, next_user_pullup_en;
	logic next_config_pins_dedicated, next_scan_pins_dedicated, next_length_error;
	logic [2:0] next_mode;

	logic is_master, is_serial, is_parallel, is_slave;
	logic clk_now, clk_prev, rise, fall, scan_rise, start;
	logic [DIV_WIDTH-1:0] half;

	always_comb begin
		is_master = (cur_mode == CMS_MODE_MSER) || (cur_mode == CMS_MODE_MPAR);
		is_slave = (cur_mode == CMS_MODE_SSER) || (cur_mode == CMS_MODE_SPAR);
		is_serial = (cur_mode == CMS_MODE_MSER) || (cur_mode == CMS_MODE_SSER);
		is_parallel = (cur_mode == CMS_MODE_MPAR) || (cur_mode == CMS_MODE_SPAR);
		// Master edges come from the generated clock, slave edges from the pin
		clk_now = is_master ? gen_clk : s_config_clock;
		clk_prev = config_clock_d;
		rise = loading && clk_now && !clk_prev;
		fall = loading && !clk_now && clk_prev;
		scan_rise = s_tck && !tck_d && scan_load_active;
		// Attempt starts on release of the program request
		start = s_prog_n && !prog_d;
		half = fast_clk_en ? fast_half_cycles : DIV_WIDTH'(CMS_CONFIG_CLOCK_HALF_CYCLES);
		if (half == '0) begin
			half = DIV_WIDTH'(1);
		end

		next_prog_d = s_prog_n;
		next_config_clock_d = clk_now;
		next_tck_d = s_tck;
		next_cur_mode = cur_mode;
		next_loading = loading;
		next_gen_clk = gen_clk;
		next_div_cnt = div_cnt;
		next_bit_cnt = bit_cnt;
		next_length_error = length_error;
		next_data_word = data_word;
		next_data_valid = 1'b0;
		next_pass_out = pass_out;

		if (!s_prog_n) begin
			next_loading = 1'b0;
			next_gen_clk = 1'b0;
			next_div_cnt = '0;
		end else if (start) begin
			next_cur_mode = cms_decode({s_m2, s_m1, s_m0});
			next_loading = 1'b1;
			next_bit_cnt = '0;
			next_length_error = 1'b0;
			next_gen_clk = 1'b0;
			next_div_cnt = '0;
		end else if (loading && load_done) begin
			next_loading = 1'b0;
			next_gen_clk = 1'b0;
		end else if (loading && is_master) begin
			if (div_cnt >= half - DIV_WIDTH'(1)) begin
				next_div_cnt = '0;
				next_gen_clk = !gen_clk;
			end else begin
				next_div_cnt = div_cnt + DIV_WIDTH'(1);
			end
		end

		// Serial and parallel data paths
		if (rise && is_serial && !length_error) begin
			next_data_word = {7'h00, s_din};
			next_data_valid = 1'b1;
			if (bit_cnt >= CMS_CHAIN_MAX_BITS) begin
				next_length_error = 1'b1;
				next_data_valid = 1'b0;
			end else begin
				next_bit_cnt = bit_cnt + 32'h00000001;
			end
		end else if (rise && is_parallel && !s_busy) begin
			next_data_word = s_pdata;
			next_data_valid = 1'b1;
		end else if (scan_rise) begin
			// Scan loading is never length checked
			next_data_word = {7'h00, s_sdi};
			next_data_valid = 1'b1;
		end

		if (fall && is_serial) begin
			next_pass_out = s_chain;
		end else if (!is_serial) begin
			next_pass_out = 1'b0;
		end

		next_pass_oe = is_serial;
		next_config_clock_out = is_master ? next_gen_clk : 1'b0;
		next_config_clock_oe = is_master;
		next_data_width = is_parallel ? 4'(CMS_PARALLEL_WIDTH) : 4'(CMS_SERIAL_WIDTH);
		next_busy = s_busy && (cur_mode == CMS_MODE_SPAR);
		// Pull-ups only during loading and only when the control pin is low
		next_user_pullup_en = next_loading && !s_pud;
		next_config_pins_dedicated = next_loading || persist;
		next_scan_pins_dedicated = 1'b1;
		next_mode = 3'(next_cur_mode);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cur_mode <= CMS_MODE_NONE;
			prog_d <= 1'b0;
			config_clock_d <= 1'b0;
			tck_d <= 1'b0;
			gen_clk <= 1'b0;
			div_cnt <= '0;
			bit_cnt <= '0;
			loading <= 1'b0;
			config_clock_out <= 1'b0;
			config_clock_oe <= 1'b0;
			pass_out <= 1'b0;
			pass_oe <= 1'b0;
			data_word <= 8'h00;
			data_width <= 4'h1;
			data_valid <= 1'b0;
			busy <= 1'b0;
			user_pullup_en <= 1'b0;
			config_pins_dedicated <= 1'b1;
			scan_pins_dedicated <= 1'b1;
			length_error <= 1'b0;
			mode <= 3'(CMS_MODE_NONE);
		end else if (ce) begin
			cur_mode <= next_cur_mode;
			prog_d <= next_prog_d;
			config_clock_d <= next_config_clock_d;
			tck_d <= next_tck_d;
			gen_clk <= next_gen_clk;
			div_cnt <= next_div_cnt;
			bit_cnt <= next_bit_cnt;
			loading <= next_loading;
			config_clock_out <= next_config_clock_out;
			config_clock_oe <= next_config_clock_oe;
			pass_out <= next_pass_out;
			pass_oe <= next_pass_oe;
			data_word <= next_data_word;
			data_width <= next_data_width;
			data_valid <= next_data_valid;
			busy <= next_busy;
			user_pullup_en <= next_user_pullup_en;
			config_pins_dedicated <= next_config_pins_dedicated;
			scan_pins_dedicated <= next_scan_pins_dedicated;
			length_error <= next_length_error;
			mode <= next_mode;
		end
	end
endmodule

/* logic/cms_pkg.sv */
package cms_pkg;
	// ----------------------------------------
	// Mode codes, as {bit2, bit1, bit0}
	// ----------------------------------------
	localparam logic [2:0] CMS_CODE_MSER = 3'h0;
	localparam logic [2:0] CMS_CODE_SSER = 3'h7;
	localparam logic [2:0] CMS_CODE_MPAR = 3'h3;
	localparam logic [2:0] CMS_CODE_SPAR = 3'h6;
	localparam logic [2:0] CMS_CODE_SCAN = 3'h5;

	// ----------------------------------------
	// Widths and limits
	// ----------------------------------------
	localparam int CMS_SERIAL_WIDTH = 1;
	localparam int CMS_PARALLEL_WIDTH = 8;
	localparam logic [31:0] CMS_CHAIN_MAX_BITS = 32'hffffffe0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CMS_CLK_MHZ = 250;
	localparam int CMS_CONFIG_CLOCK_DEFAULT_MHZ = 6;
	localparam int CMS_CONFIG_CLOCK_HALF_CYCLES = (CMS_CLK_MHZ + 2 * CMS_CONFIG_CLOCK_DEFAULT_MHZ - 1)
		/ (2 * CMS_CONFIG_CLOCK_DEFAULT_MHZ);
	localparam int CMS_DIV_WIDTH = 8;

	typedef enum logic [2:0] {
		CMS_MODE_MSER,
		CMS_MODE_SSER,
		CMS_MODE_MPAR,
		CMS_MODE_SPAR,
		CMS_MODE_SCAN,
		CMS_MODE_NONE
	} cms_mode_e;
endpackage

/* logic/cms_sync.sv */
`timescale 1ns/1ns
module cms_sync
	import cms_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_q;

	always_comb begin
		next_stage1 = ce ? d : stage1;
		next_q = ce ? stage1 : q;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stage1 <= '0;
			q <= '0;
		end else begin
			stage1 <= next_stage1;
			q <= next_q;
		end
	end
endmodule

/* test/cms_props.sv */
`timescale 1ns/1ns
module cms_props
	import cms_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic fast_clk_en,
	input wire logic persist,
	input wire logic program_request_n,
	input wire logic io_pullup_disable,
	input wire logic config_clock_out,
	input wire logic config_clock_oe,
	input wire logic pass_oe,
	input wire logic [3:0] data_width,
	input wire logic data_valid,
	input wire logic loading,
	input wire logic user_pullup_en,
	input wire logic config_pins_dedicated,
	input wire logic [2:0] mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire logic mst = mode == CMS_MODE_MSER || mode == CMS_MODE_MPAR;
	wire logic ser = mode == CMS_MODE_MSER || mode == CMS_MODE_SSER;
	wire logic par = mode == CMS_MODE_MPAR || mode == CMS_MODE_SPAR;
	clk_dir_a: assert property (loading && $stable(mode) |-> config_clock_oe == mst)
		else $error("clock direction");
	pass_dir_a: assert property (loading && $stable(mode) |-> pass_oe == ser)
		else $error("pass direction");
	load_width_a: assert property (loading && $stable(mode)
		|-> data_width == (par ? 4'h8 : 4'h1)) else $error("data width");
	pullup_ctrl_a: assert property (loading && $past(loading, 4)
		&& io_pullup_disable == $past(io_pullup_disable, 4)
		|-> user_pullup_en == !io_pullup_disable) else $error("pull-up control");
	valid_pulse_a: assert property (data_valid |=> !data_valid)
		else $error("valid pulse");
	mode_hold_a: assert property (loading && $past(loading) |-> $stable(mode))
		else $error("mode hold");
	pin_role_a: assert property (program_request_n && $past(program_request_n, 8)
		&& !loading && !$past(loading, 8) && mode != CMS_MODE_NONE
		&& persist == $past(persist, 8) |-> config_pins_dedicated == persist)
		else $error("pin role");
	master_clk_a: assert property (loading && mst && !fast_clk_en
		&& $rose(config_clock_out) |-> ##21 ($fell(config_clock_out) || !loading))
		else $error("master clock rate");
endmodule
bind cms_config_mode_select cms_props i_cms_props (.clk, .nrst, .fast_clk_en, .persist,
	.program_request_n, .io_pullup_disable, .config_clock_out, .config_clock_oe, .pass_oe,
	.data_width, .data_valid, .loading, .user_pullup_en, .config_pins_dedicated, .mode);

/* test/cms_far_side.sv */
`timescale 1ns/1ns
module cms_far_side (
	input wire logic slave_run,
	input wire logic scan_run,
	output logic config_clock_in,
	output logic test_clock
);
	initial begin
		config_clock_in = 1'b0;
		test_clock = 1'b0;
		#7;
		forever begin
			#80;
			config_clock_in = slave_run & ~config_clock_in;
			test_clock = scan_run & ~test_clock;
		end
	end
endmodule

/* test/test_config_mode_select.sv */
`timescale 1ns/1ns
module test_config_mode_select;
	import cms_pkg::*;
	logic clk, nrst, ce, mode_select_bit0, mode_select_bit1, mode_select_bit2;
	logic io_pullup_disable, program_request_n, persist, load_done, fast_clk_en;
	logic [7:0] fast_half_cycles, parallel_data_in, data_word;
	logic config_clock_in, test_clock, serial_data_in, chain_data_in, scan_load_active;
	logic scan_data_in, busy_in, config_clock_out, config_clock_oe, pass_out, pass_oe;
	logic data_valid, busy, loading, user_pullup_en, config_pins_dedicated;
	logic scan_pins_dedicated, length_error, slave_run, scan_run, mst, scn;
	logic [3:0] data_width;
	logic [2:0] mode;
	logic [19:0] note;
	logic [19:0] notes[$];
	logic [31:0] seed;
	int miscompares, comparisons;
	wire logic src = mst ? config_clock_out : scn ? test_clock : config_clock_in;
	cms_config_mode_select i_cms_config_mode_select (.clk, .nrst, .ce, .mode_select_bit0,
		.mode_select_bit1, .mode_select_bit2, .io_pullup_disable, .program_request_n, .persist,
		.load_done, .fast_clk_en, .fast_half_cycles, .config_clock_in, .test_clock,
		.serial_data_in, .parallel_data_in, .chain_data_in, .scan_load_active, .scan_data_in,
		.busy_in, .config_clock_out, .config_clock_oe, .pass_out, .pass_oe, .data_word,
		.data_width, .data_valid, .busy, .loading, .user_pullup_en, .config_pins_dedicated,
		.scan_pins_dedicated, .length_error, .mode);
	cms_far_side i_cms_far_side (.slave_run, .scan_run, .config_clock_in, .test_clock);
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task check(string name, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task conclude();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Present the next unit and note what the design must load from it
	task put(logic par);
		logic [31:0] r;
		r = rnd();
		{chain_data_in, parallel_data_in} = r[8:0];
		serial_data_in = r[0];
		scan_data_in = r[0];
		notes.push_back({par ? 12'h8ff : 12'h101, r[7:0] & (par ? 8'hff : 8'h01)});
	endtask
	always @(negedge clk) begin
		if (data_valid === 1'b1) begin
			note = notes.size() > 0 ? notes.pop_front() : 20'hfffff;
			check("word", note[7:0], data_word & note[15:8]);
			check("width", note[19:16], data_width);
		end
	end
	task attempt(logic [2:0] code, cms_mode_e emode, logic scan, int n);
		logic par;
		logic [31:0] r;
		int k;
		par = code == CMS_CODE_MPAR || code == CMS_CODE_SPAR;
		r = rnd();
		{mode_select_bit2, mode_select_bit1, mode_select_bit0} = code;
		{persist, io_pullup_disable, fast_half_cycles} = r[9:0];
		fast_half_cycles = fast_half_cycles | 8'h20;
		fast_clk_en = code == CMS_CODE_MPAR;
		program_request_n = 1'b0;
		mst = code == CMS_CODE_MSER || code == CMS_CODE_MPAR;
		scn = scan;
		if (n > 0) put(par);
		repeat (4) @(negedge clk);
		program_request_n = 1'b1;
		for (k = 0; k < 20 && loading !== 1'b1; k++) @(negedge clk);
		check("mode", emode, mode);
		if (n > 0) check("pullup", !io_pullup_disable, user_pullup_en);
		{mode_select_bit2, mode_select_bit1, mode_select_bit0} = r[12:10];
		busy_in = 1'b1;
		repeat (4) @(negedge clk);
		check("busy", code == CMS_CODE_SPAR, busy);
		busy_in = 1'b0;
		repeat (4) @(negedge clk);
		slave_run = !mst && !scan && n > 0;
		scan_run = scan;
		scan_load_active = scan;
		for (k = 0; k < n; k++) begin
			@(posedge src);
			if (fast_clk_en) begin
				repeat (fast_half_cycles) @(negedge clk);
				check("fast high", 1, config_clock_out);
				@(negedge clk);
				check("fast low", 0, config_clock_out);
			end else begin
				@(negedge src);
			end
			repeat (5) @(negedge clk);
			if (!par && !scan) check("pass", chain_data_in, pass_out);
			else if (code != CMS_CODE_SSER) check("oe", 0, pass_oe);
			if (k < n - 1) put(par);
		end
		{slave_run, scan_run, scan_load_active, load_done} = 4'h1;
		@(negedge clk);
		load_done = 1'b0;
		repeat (8) @(negedge clk);
		check("mode", emode, mode);
		if (n > 0) check("role", persist, config_pins_dedicated);
		if (n > 0) check("pending", 0, notes.size());
		check("scan", 1, scan_pins_dedicated);
		check("length", 0, length_error);
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#200000;
		miscompares++;
		conclude();
	end
	initial begin
		seed = 32'h83196835;
		{nrst, program_request_n, persist, load_done, fast_clk_en, busy_in, mst, scn} = 8'h0;
		{slave_run, scan_run, scan_load_active, serial_data_in, scan_data_in} = 5'h0;
		{mode_select_bit0, mode_select_bit1, mode_select_bit2, io_pullup_disable} = 4'h0;
		{parallel_data_in, fast_half_cycles, chain_data_in, ce} = 18'h1;
		repeat (8) @(negedge clk);
		nrst = 1'b1;
		attempt(CMS_CODE_MSER, CMS_MODE_MSER, 1'b0, 5);
		attempt(CMS_CODE_SSER, CMS_MODE_SSER, 1'b0, 5);
		attempt(CMS_CODE_MPAR, CMS_MODE_MPAR, 1'b0, 5);
		attempt(CMS_CODE_SPAR, CMS_MODE_SPAR, 1'b0, 5);
		attempt(CMS_CODE_SCAN, CMS_MODE_SCAN, 1'b1, 5);
		attempt(CMS_CODE_SSER, CMS_MODE_SSER, 1'b1, 5);
		attempt(3'h1, CMS_MODE_NONE, 1'b0, 0);
		ce = 1'b0;
		program_request_n = 1'b0;
		repeat (4) @(negedge clk);
		program_request_n = 1'b1;
		repeat (8) @(negedge clk);
		check("frozen", 0, loading);
		conclude();
	end
endmodule
